// ==== src/dspb_pkg.sv ====
// Purpose: bank constants
// Assumes: 10 MHz mclk
// Notes: code numbers serve as addresses
`default_nettype none
package dspb_pkg;
   // ****************************************************
   // clock and link timing
   // ****************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int BAUD_0_HZ = 9600;
   localparam int BAUD_1_HZ = 4800;
   localparam int BAUD_2_HZ = 2400;
   localparam int BAUD_3_HZ = 1200;
   localparam int DIV_W = 14;
   localparam logic [DIV_W-1:0] DIV_0 = DIV_W'(CLK_HZ / BAUD_0_HZ);
   localparam logic [DIV_W-1:0] DIV_1 = DIV_W'(CLK_HZ / BAUD_1_HZ);
   localparam logic [DIV_W-1:0] DIV_2 = DIV_W'(CLK_HZ / BAUD_2_HZ);
   localparam logic [DIV_W-1:0] DIV_3 = DIV_W'(CLK_HZ / BAUD_3_HZ);
   localparam logic [DIV_W-1:0] DIV_ONE = 14'h0001;

   // ****************************************************
   // code numbers
   // ****************************************************
   localparam int CODE_W = 11;
   localparam logic [CODE_W-1:0] CODE_STATION = 11'h009;
   localparam logic [CODE_W-1:0] CODE_FAULT = 11'h02B;
   localparam logic [CODE_W-1:0] CODE_STATE_WIDE = 11'h044;
   localparam logic [CODE_W-1:0] CODE_STATE_NARROW = 11'h045;
   localparam logic [CODE_W-1:0] CODE_RATE = 11'h07D;
   localparam logic [CODE_W-1:0] CODE_HIST_NEWEST = 11'h0A1;
   localparam logic [CODE_W-1:0] CODE_HIST_OLDEST = 11'h0A8;
   localparam logic [CODE_W-1:0] CODE_WINDOW = 11'h0F9;
   localparam logic [CODE_W-1:0] CODE_MODULE_EN = 11'h172;
   localparam logic [CODE_W-1:0] CODE_LAST = 11'h7D0;
   localparam logic [CODE_W-1:0] WINDOW_STEP = 11'h0FA;

   // ****************************************************
   // value limits and resets
   // ****************************************************
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'h63;
   localparam logic [7:0] ADDR_GROUP = 8'h0A;
   localparam logic [7:0] ADDR_RESET = 8'h01;
   localparam logic [2:0] WINDOW_MAX = 3'h7;
   localparam logic [2:0] WINDOW_RESET = 3'h0;
   localparam logic [1:0] RATE_RESET = 2'h0;
   localparam logic MODULE_EN_RESET = 1'b0;
   localparam int HIST_DEPTH = 8;
   localparam int TRIP_W = 8;

   // ****************************************************
   // wide state word bit positions
   // ****************************************************
   localparam int SW_TRIP = 15;
   localparam int SW_ILIM = 13;
   localparam int SW_QSTOP = 12;
   localparam int SW_PINH = 11;
   localparam int SW_RUN = 10;
   localparam int SW_ZSPD = 9;
   localparam int SW_CEN = 8;
   localparam int SW_COMM_HI = 7;
   localparam int SW_COMM_LO = 4;
   localparam int SW_OPER_HI = 3;
   localparam int SW_OPER_LO = 0;

   // ****************************************************
   // narrow state word bit positions
   // ****************************************************
   localparam int SN_CEN = 7;
   localparam int SN_SPARE = 6;
   localparam int SN_CRST = 5;
   localparam int SN_TERM = 4;
   localparam int SN_SER = 3;
   localparam int SN_PRECHARGE_FLAG = 2;
   localparam int SN_CERR = 1;
   localparam int SN_OERR = 0;
endpackage : dspb_pkg
`default_nettype wire

// ==== src/dspb_trip_history.sv ====
// Purpose: reset trip history, newest at 0
// Assumes: one push per cleared trip
// Notes: entries age by one slot per push
`default_nettype none
module dspb_trip_history
   import dspb_pkg::*;
#(
   parameter int DEPTH = HIST_DEPTH,
   parameter int WIDTH = TRIP_W
) (
   input wire logic mclk, // system clock
   input wire logic resetn, // sync reset, low
   input wire logic push, // store a reset trip
   input wire logic [WIDTH-1:0] push_code, // trip code stored
   input wire logic [$clog2(DEPTH)-1:0] rd_idx, // 0 is newest
   output logic [WIDTH-1:0] rd_code // entry at rd_idx
);
   logic [WIDTH-1:0] hist_reg [DEPTH];

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            hist_reg[i] <= '0;
         end
      end else if (push) begin
         hist_reg[0] <= push_code; // RULE_13
         for (int i = 1; i < DEPTH; i++) begin
            hist_reg[i] <= hist_reg[i-1]; // RULE_13
         end
      end
   end

   assign rd_code = hist_reg[rd_idx]; // RULE_12
endmodule : dspb_trip_history
`default_nettype wire

// ==== src/dspb_bank.sv ====
// Purpose: drive parameter and status code bank
// Assumes: inputs synchronous to mclk
// Notes: answer one cycle after a request
//
// Operation
// (RULE_01) station address only one to ninety-nine
// (RULE_02) multiples of ten are broadcast groups
// (RULE_03) link serves at most ninety controllers
// (RULE_04) fault reads one, acknowledged by writing zero
// (RULE_05) acknowledge clears only once cause gone
// (RULE_06) fault and state words hidden locally
// (RULE_07) wide state word flag bit positions
// (RULE_08) wide word low bytes carry error codes
// (RULE_09) narrow state word flag bit positions
// (RULE_10) narrow word bit six reads zero
// (RULE_11) rate select picks baud, default 9600
// (RULE_12) eight read-only trip history codes
// (RULE_13) newest reset trip first, older follow
// (RULE_14) direct serial reach only up to 255
// (RULE_15) window select zero to seven, step 250
// (RULE_16) module link enable gates module traffic
// (RULE_17) ready asserted even without fitted module
// (RULE_18) factory default keeps module link enable
// (RULE_19) operator sets mode four to seven
// (RULE_20) acknowledge ignored while trip source active
`default_nettype none
module dspb_bank
   import dspb_pkg::*;
#(
   parameter logic [7:0] STATION_DEFAULT = ADDR_RESET
) (
   input wire logic mclk, // system clock
   input wire logic resetn, // sync reset, low
   input wire logic req_valid, // access request
   input wire logic req_write, // 1 write, 0 read
   input wire logic req_serial, // 1 serial, 0 local
   input wire logic [CODE_W-1:0] req_code, // window offset or code
   input wire logic [15:0] req_wdata, // write value
   output logic resp_valid, // answer pulse
   output logic resp_error, // refused access
   output logic [15:0] resp_rdata, // read value
   input wire logic rx_addr_valid, // address of a telegram seen
   input wire logic [7:0] rx_addr, // that address
   output logic addr_match, // telegram is for this station
   output logic addr_broadcast, // group match
   output logic baud_tick, // one pulse per bit time
   input wire logic trip_source, // a trip cause is active
   input wire logic [TRIP_W-1:0] trip_code, // code of that cause
   input wire logic ext_trip_ack, // terminal acknowledge
   input wire logic factory_default_load, // load default set pulse
   input wire logic module_fitted, // module present
   input wire logic current_limit_flag, // current at limit
   input wire logic quick_stop_flag, // quick stop active
   input wire logic running, // drive running
   input wire logic zero_speed, // actual speed zero
   input wire logic ctrl_enable, // controller enabled
   input wire logic ctrl_reset, // controller in reset
   input wire logic terminal_ctrl, // terminal control
   input wire logic serial_control_flag, // serial link control
   input wire logic precharge_flag, // precharge state
   input wire logic comm_error_flag, // comm error
   input wire logic operation_error_flag, // operation error
   input wire logic [3:0] comm_err_code, // comm error code
   input wire logic [3:0] oper_err_code, // operation error code
   output logic trip_state, // drive tripped
   output logic pulse_inhibit_flag, // pulses inhibited
   output logic ready_out, // ready message
   output logic module_comm_en, // module traffic
   output logic [7:0] station_addr, // own address
   output logic [1:0] link_rate // chosen rate
);
   // ****************************************************
   // registers
   // ****************************************************
   logic [7:0] station_address_reg, station_address_next;
   logic fault_indicate_ack_reg, fault_indicate_ack_next;
   logic [1:0] link_rate_select_reg, link_rate_select_next;
   logic [2:0] code_window_select_reg, code_window_select_next;
   logic module_link_enable_reg, module_link_enable_next;
   logic trip_src_d_reg;
   logic [TRIP_W-1:0] trip_code_reg, trip_code_next;
   logic resp_valid_reg, resp_error_reg;
   logic [15:0] resp_rdata_reg;
   logic match_reg, bcast_reg, tick_reg, ready_reg, modc_reg;
   logic [DIV_W-1:0] div_reg, div_next;

   // ****************************************************
   // code decode
   // ****************************************************
   wire [CODE_W-1:0] win_base;
   wire [CODE_W-1:0] abs_code;
   wire code_range_ok;
   wire is_station, is_fault, is_wide, is_narrow, is_rate;
   wire is_window, is_modena, is_hist, is_hidden;
   wire [2:0] hist_idx;
   wire [TRIP_W-1:0] hist_code;

   assign win_base = CODE_W'(code_window_select_reg * WINDOW_STEP); // RULE_15
   // serial offset within one window
   assign abs_code = req_serial ?
      CODE_W'(win_base + {3'h0, req_code[7:0]}) : req_code; // RULE_14
   assign code_range_ok = (abs_code <= CODE_LAST) &&
      (!req_serial || req_code[CODE_W-1:8] == 3'h0); // RULE_14 RULE_15
   assign is_station = (abs_code == CODE_STATION);
   assign is_fault = (abs_code == CODE_FAULT);
   assign is_wide = (abs_code == CODE_STATE_WIDE);
   assign is_narrow = (abs_code == CODE_STATE_NARROW);
   assign is_rate = (abs_code == CODE_RATE);
   assign is_window = (abs_code == CODE_WINDOW);
   assign is_modena = (abs_code == CODE_MODULE_EN);
   assign is_hist = (abs_code >= CODE_HIST_NEWEST) &&
      (abs_code <= CODE_HIST_OLDEST); // RULE_12
   assign hist_idx = 3'(abs_code - CODE_HIST_NEWEST);
   assign is_hidden = !req_serial &&
      (is_fault || is_wide || is_narrow); // RULE_06

   // ****************************************************
   // state words
   // ****************************************************
   wire [15:0] state_wide;
   wire [7:0] state_narrow;
   assign state_wide[SW_TRIP] = fault_indicate_ack_reg; // RULE_07
   assign state_wide[SW_TRIP-1] = 1'b0;
   assign state_wide[SW_ILIM] = current_limit_flag; // RULE_07
   assign state_wide[SW_QSTOP] = quick_stop_flag; // RULE_07
   assign state_wide[SW_PINH] = fault_indicate_ack_reg; // RULE_07
   assign state_wide[SW_RUN] = running; // RULE_07
   assign state_wide[SW_ZSPD] = zero_speed; // RULE_07
   assign state_wide[SW_CEN] = ctrl_enable; // RULE_07
   assign state_wide[SW_COMM_HI:SW_COMM_LO] = comm_err_code; // RULE_08
   assign state_wide[SW_OPER_HI:SW_OPER_LO] = oper_err_code; // RULE_08
   assign state_narrow[SN_CEN] = ctrl_enable; // RULE_09
   assign state_narrow[SN_SPARE] = 1'b0; // RULE_10
   assign state_narrow[SN_CRST] = ctrl_reset; // RULE_09
   assign state_narrow[SN_TERM] = terminal_ctrl; // RULE_09
   assign state_narrow[SN_SER] = serial_control_flag; // RULE_09
   assign state_narrow[SN_PRECHARGE_FLAG] = precharge_flag; // RULE_09
   assign state_narrow[SN_CERR] = comm_error_flag; // RULE_09
   assign state_narrow[SN_OERR] = operation_error_flag; // RULE_09

   // ****************************************************
   // access checks
   // ****************************************************
   wire [7:0] wr_addr;
   wire addr_ok, addr_group;
   wire acc_ok, wr_ok, wr_bad;
   assign wr_addr = req_wdata[7:0];
   assign addr_group = (wr_addr % ADDR_GROUP) == 8'h00; // RULE_02
   assign addr_ok = (req_wdata[15:8] == 8'h00) && (wr_addr >= ADDR_MIN) &&
      (wr_addr <= ADDR_MAX) && !addr_group; // RULE_01 RULE_03
   assign acc_ok = req_valid && code_range_ok && !is_hidden &&
      (is_station || is_fault || is_wide || is_narrow || is_rate ||
       is_window || is_modena || is_hist);
   assign wr_bad = (is_station && !addr_ok) ||
      (is_fault && req_wdata != 16'h0000) ||
      (is_rate && req_wdata[15:2] != 14'h0000) ||
      (is_window && req_wdata > {13'h0000, WINDOW_MAX}) || // RULE_15
      (is_modena && req_wdata[15:1] != 15'h0000) ||
      is_wide || is_narrow || is_hist; // RULE_12
   assign wr_ok = acc_ok && req_write && !wr_bad;

   // ****************************************************
   // fault, acknowledge and trip history
   // ****************************************************
   wire trip_rise, ack_req, ack_done;
   assign trip_rise = trip_source && !trip_src_d_reg;
   assign ack_req = (wr_ok && is_fault) || ext_trip_ack; // RULE_04
   // no acknowledge while a cause stays
   assign ack_done = ack_req && fault_indicate_ack_reg &&
      !trip_source && !trip_rise; // RULE_05 RULE_20

   always_comb begin
      fault_indicate_ack_next = fault_indicate_ack_reg;
      trip_code_next = trip_code_reg;
      if (trip_source) begin
         fault_indicate_ack_next = 1'b1; // RULE_04 RULE_20
         trip_code_next = trip_code;
      end else if (ack_done) begin
         fault_indicate_ack_next = 1'b0; // RULE_05
      end
   end

   dspb_trip_history #(
      .DEPTH(HIST_DEPTH),
      .WIDTH(TRIP_W)
   ) u_hist (
      .mclk(mclk),
      .resetn(resetn),
      .push(ack_done), // RULE_13
      .push_code(trip_code_reg),
      .rd_idx(hist_idx),
      .rd_code(hist_code)
   );

   // ****************************************************
   // writable settings
   // ****************************************************
   always_comb begin
      station_address_next = station_address_reg;
      link_rate_select_next = link_rate_select_reg;
      code_window_select_next = code_window_select_reg;
      module_link_enable_next = module_link_enable_reg;
      if (factory_default_load) begin
         station_address_next = STATION_DEFAULT;
         link_rate_select_next = RATE_RESET; // RULE_11
         code_window_select_next = WINDOW_RESET;
         // module link enable kept  RULE_18
      end else if (wr_ok) begin
         if (is_station) begin
            station_address_next = wr_addr; // RULE_01
         end else if (is_rate) begin
            link_rate_select_next = req_wdata[1:0]; // RULE_11
         end else if (is_window) begin
            code_window_select_next = req_wdata[2:0]; // RULE_15
         end else if (is_modena) begin
            module_link_enable_next = req_wdata[0]; // RULE_16
         end
      end
   end

   // ****************************************************
   // read mux
   // ****************************************************
   wire [15:0] rd_val;
   assign rd_val = is_station ? {8'h00, station_address_reg} :
      is_fault ? {15'h0000, fault_indicate_ack_reg} : // RULE_04
      is_wide ? state_wide :
      is_narrow ? {8'h00, state_narrow} :
      is_rate ? {14'h0000, link_rate_select_reg} :
      is_window ? {13'h0000, code_window_select_reg} :
      is_modena ? {15'h0000, module_link_enable_reg} :
      is_hist ? {8'h00, hist_code} : 16'h0000;

   // ****************************************************
   // station address match
   // ****************************************************
   wire rx_group, rx_own, rx_grp_hit;
   assign rx_group = (rx_addr % ADDR_GROUP) == 8'h00 && rx_addr != 8'h00;
   assign rx_own = rx_addr == station_address_reg; // RULE_01
   assign rx_grp_hit = rx_group &&
      (rx_addr / ADDR_GROUP) == (station_address_reg / ADDR_GROUP); // RULE_02

   // ****************************************************
   // baud divider
   // ****************************************************
   wire [DIV_W-1:0] div_load;
   assign div_load = (link_rate_select_reg == 2'h0) ? DIV_0 :
      (link_rate_select_reg == 2'h1) ? DIV_1 :
      (link_rate_select_reg == 2'h2) ? DIV_2 : DIV_3; // RULE_11
   wire div_end;
   assign div_end = (div_reg <= DIV_ONE);
   assign div_next = div_end ? div_load : DIV_W'(div_reg - DIV_ONE);

   // ****************************************************
   // flip-flops
   // ****************************************************
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         station_address_reg <= STATION_DEFAULT;
         fault_indicate_ack_reg <= 1'b0;
         link_rate_select_reg <= RATE_RESET;
         code_window_select_reg <= WINDOW_RESET;
         module_link_enable_reg <= MODULE_EN_RESET;
         trip_src_d_reg <= 1'b0;
         trip_code_reg <= '0;
         div_reg <= DIV_0;
      end else begin
         station_address_reg <= station_address_next;
         fault_indicate_ack_reg <= fault_indicate_ack_next;
         link_rate_select_reg <= link_rate_select_next;
         code_window_select_reg <= code_window_select_next;
         module_link_enable_reg <= module_link_enable_next;
         trip_src_d_reg <= trip_source;
         trip_code_reg <= trip_code_next;
         div_reg <= div_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         resp_valid_reg <= 1'b0;
         resp_error_reg <= 1'b0;
         resp_rdata_reg <= 16'h0000;
         match_reg <= 1'b0;
         bcast_reg <= 1'b0;
         tick_reg <= 1'b0;
         ready_reg <= 1'b0;
         modc_reg <= 1'b0;
      end else begin
         resp_valid_reg <= req_valid;
         resp_error_reg <= req_valid && (!acc_ok || (req_write && wr_bad));
         resp_rdata_reg <= (acc_ok && !req_write) ? rd_val : 16'h0000;
         match_reg <= rx_addr_valid && (rx_own || rx_grp_hit);
         bcast_reg <= rx_addr_valid && rx_grp_hit; // RULE_02
         tick_reg <= div_end;
         ready_reg <= !fault_indicate_ack_next; // RULE_17
         modc_reg <= module_link_enable_next && module_fitted; // RULE_16
      end
   end

   assign resp_valid = resp_valid_reg;
   assign resp_error = resp_error_reg;
   assign resp_rdata = resp_rdata_reg;
   assign addr_match = match_reg;
   assign addr_broadcast = bcast_reg;
   assign baud_tick = tick_reg;
   assign trip_state = fault_indicate_ack_reg; // RULE_20
   assign pulse_inhibit_flag = fault_indicate_ack_reg; // RULE_20
   assign ready_out = ready_reg;
   assign module_comm_en = modc_reg;
   assign station_addr = station_address_reg;
   assign link_rate = link_rate_select_reg;
endmodule : dspb_bank
`default_nettype wire

// ==== tb/dspb_bank_props.sv ====
// Purpose: port checker for the bank
// Assumes: one mclk domain, sync low reset
// Notes: bound into dspb_bank, ports only
`default_nettype none
module dspb_bank_props
   import dspb_pkg::*;
(
   input wire logic mclk, // clock
   input wire logic resetn, // sync reset, low
   input wire logic req_valid, // access request
   input wire logic req_write, // write
   input wire logic resp_valid, // answer pulse
   input wire logic rx_addr_valid, // address strobe
   input wire logic [7:0] rx_addr, // address
   input wire logic addr_match, // station hit
   input wire logic addr_broadcast, // group hit
   input wire logic baud_tick, // bit time pulse
   input wire logic trip_source, // trip cause active
   input wire logic factory_default_load, // default set load
   input wire logic module_fitted, // module present
   input wire logic trip_state, // drive tripped
   input wire logic pulse_inhibit_flag, // pulses inhibited
   input wire logic ready_out, // ready
   input wire logic module_comm_en, // module traffic
   input wire logic [7:0] station_addr, // own address
   input wire logic [1:0] link_rate // chosen rate
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   AST_RESP_NEXT: assert property (req_valid |=> resp_valid)
      else $error("no answer");
   AST_RESP_SPUR: assert property (!req_valid |=> !resp_valid)
      else $error("stray answer");
   AST_FAULT_SET: assert property (trip_source |=> trip_state)
      else $error("trip not latched");
   AST_FAULT_QUIET: assert property (
      !trip_state && !trip_source |=> !trip_state)
      else $error("stray fault");
   AST_PINH_TRIP: assert property (pulse_inhibit_flag == trip_state)
      else $error("inhibit not trip");
   AST_READY: assert property (
      $past(resetn) |-> ready_out == !trip_state)
      else $error("ready wrong");
   AST_STATION: assert property (
      station_addr >= 8'h01 && station_addr <= 8'h63
      && (station_addr % 8'h0A) != 8'h00)
      else $error("bad station");
   AST_RATE_HOLD: assert property (
      !(req_valid && req_write) && !factory_default_load
      |=> $stable(link_rate))
      else $error("rate changed");
   AST_MOD_GATE: assert property (
      !module_fitted |=> !module_comm_en)
      else $error("traffic without module");
   AST_BAUD_GAP: assert property (baud_tick |=> !baud_tick [*8])
      else $error("ticks too close");
   AST_MATCH: assert property (
      rx_addr_valid && rx_addr == station_addr |=> addr_match)
      else $error("own address missed");
   AST_NO_MATCH: assert property (
      !rx_addr_valid |=> !addr_match && !addr_broadcast)
      else $error("stray match");
   AST_BCAST: assert property (addr_broadcast |-> addr_match)
      else $error("group without match");
endmodule : dspb_bank_props

bind dspb_bank dspb_bank_props u_props (.*);
`default_nettype wire

// ==== tb/dspb_host_model.sv ====
// Purpose: host sending telegram addresses
// Assumes: lines change after falling mclk
// Notes: released lines show inverse; mode 4-7 set by operator
`default_nettype none
module dspb_host_model (
   input wire logic mclk, // system clock
   output logic rx_addr_valid, // telegram address strobe
   output logic [7:0] rx_addr // telegram address
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      rx_addr_valid = 1'b0;
      rx_addr = 8'h00;
   end
   task automatic send(input logic [7:0] a);
      if (a < 8'h01 || a > 8'h63) return;
      @(negedge mclk);
      rx_addr_valid = 1'b1;
      rx_addr = a;
      @(negedge mclk);
      rx_addr_valid = 1'b0;
      rx_addr = ~a;
   endtask : send
endmodule : dspb_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: directed bank tests
// Assumes: inputs driven at falling mclk
// Notes: expectations from package constants
`default_nettype none
module testbench
   import dspb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic req_serial = 1'b0, trip_source = 1'b0, ext_trip_ack = 1'b0;
   logic factory_default_load = 1'b0, module_fitted = 1'b0;
   logic [CODE_W-1:0] req_code = '0;
   logic [15:0] req_wdata = '0;
   logic [TRIP_W-1:0] trip_code = '0;
   logic [10:0] flg = '0;
   logic [3:0] comm_err_code = '0, oper_err_code = '0;
   wire logic current_limit_flag, quick_stop_flag, running, zero_speed;
   wire logic ctrl_enable, ctrl_reset, terminal_ctrl, serial_control_flag;
   wire logic precharge_flag, comm_error_flag, operation_error_flag;
   logic resp_valid, resp_error, addr_match, addr_broadcast, baud_tick;
   logic trip_state, pulse_inhibit_flag, ready_out, module_comm_en;
   logic [15:0] resp_rdata;
   logic [7:0] station_addr;
   logic [1:0] link_rate;
   wire logic rx_addr_valid;
   wire logic [7:0] rx_addr;
   logic [13:0] gap;
   int num_errors = 0, num_checks = 0;
   logic [7:0] sv[6] = '{8'h00, 8'h0A, 8'h5A, 8'h64, 8'h32, 8'h17};
   logic [10:0] hid[3] = '{CODE_FAULT, CODE_STATE_WIDE, CODE_STATE_NARROW};
   logic [10:0] fp[2] = '{11'h555, 11'h2AA};
   logic [15:0] ew[2] = '{16'h25A5, 16'h125A};
   logic [15:0] en[2] = '{16'h0095, 16'h002A};
   logic [13:0] dv[4] = '{DIV_0, DIV_1, DIV_2, DIV_3};
   assign {current_limit_flag, quick_stop_flag, running, zero_speed,
      ctrl_enable, ctrl_reset, terminal_ctrl, serial_control_flag,
      precharge_flag, comm_error_flag, operation_error_flag} = flg;

   dspb_bank dut (.*);
   dspb_host_model host (.*);

   always #50 mclk = ~mclk;

   // ****************************************************
   // access and compare tasks
   // ****************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic w, s, input logic [10:0] c,
      input logic [15:0] wd, input logic e, input logic [15:0] exp);
      @(negedge mclk);
      req_valid = 1'b1;
      req_write = w;
      req_serial = s;
      req_code = c;
      req_wdata = wd;
      @(negedge mclk);
      req_valid = 1'b0;
      check(16'({resp_valid, resp_error}), 16'({1'b1, e}));
      check(resp_rdata, exp);
   endtask : acc
   task automatic wr(input logic [10:0] c, input logic [15:0] wd,
      input logic e);
      acc(1'b1, 1'b1, c, wd, e, 16'h0000);
   endtask : wr
   task automatic rd(input logic [10:0] c, input logic [15:0] exp);
      acc(1'b0, 1'b1, c, 16'h0000, 1'b0, exp);
   endtask : rd
   task automatic tick_gap(output logic [13:0] n);
      int c;
      for (int k = 0; k < 3; k++) begin
         c = 0;
         do begin
            @(negedge mclk);
            c++;
         end while (baud_tick !== 1'b1 && c < 20000);
      end
      n = 14'(c);
   endtask : tick_gap
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      #6_000_000;
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (8) @(negedge mclk);
      resetn = 1'b1;
      rd(CODE_STATION, 16'h0001);
      rd(CODE_RATE, 16'h0000);
      rd(CODE_WINDOW, 16'h0000);
      rd(CODE_FAULT, 16'h0000);
      check(16'(ready_out), 16'h0001);
      $display("reset done");
      for (int i = 0; i < 6; i++)
         wr(CODE_STATION, {8'h00, sv[i]}, i < 5);
      rd(CODE_STATION, 16'h0017);
      check(16'(station_addr), 16'h0017);
      host.send(8'h17);
      check(16'({addr_match, addr_broadcast}), 16'h0002);
      host.send(8'h14);
      check(16'({addr_match, addr_broadcast}), 16'h0003);
      host.send(8'h1E);
      check(16'({addr_match, addr_broadcast}), 16'h0000);
      $display("address done");
      trip_code = 8'h5A;
      trip_source = 1'b1;
      @(negedge mclk);
      check(16'(pulse_inhibit_flag), 16'h0001);
      check(16'(ready_out), 16'h0000);
      rd(CODE_STATE_WIDE, 16'h8800);
      wr(CODE_FAULT, 16'h0000, 1'b0);
      rd(CODE_FAULT, 16'h0001);
      trip_source = 1'b0;
      wr(CODE_FAULT, 16'h0001, 1'b1);
      wr(CODE_FAULT, 16'h0000, 1'b0);
      rd(CODE_FAULT, 16'h0000);
      trip_code = 8'h3C;
      trip_source = 1'b1;
      @(negedge mclk);
      trip_source = 1'b0;
      ext_trip_ack = 1'b1;
      @(negedge mclk);
      ext_trip_ack = 1'b0;
      check(16'(trip_state), 16'h0000);
      rd(CODE_HIST_NEWEST, 16'h003C);
      rd(CODE_HIST_NEWEST + 11'h001, 16'h005A);
      rd(CODE_HIST_OLDEST, 16'h0000);
      wr(CODE_HIST_NEWEST, 16'h0001, 1'b1);
      $display("fault done");
      for (int i = 0; i < 3; i++)
         acc(1'b0, 1'b0, hid[i], 16'h0000, 1'b1, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         flg = fp[i];
         comm_err_code = i ? 4'h5 : 4'hA;
         oper_err_code = ~comm_err_code;
         rd(CODE_STATE_WIDE, ew[i]);
         rd(CODE_STATE_NARROW, en[i]);
      end
      wr(CODE_STATE_WIDE, 16'h0001, 1'b1);
      $display("state done");
      for (int r = 0; r < 4; r++) begin
         wr(CODE_RATE, 16'(r), 1'b0);
         check(16'(link_rate), 16'(r));
         tick_gap(gap);
         check(16'(gap), 16'(dv[r]));
      end
      wr(CODE_RATE, 16'h0004, 1'b1);
      $display("rate done");
      wr(CODE_WINDOW, 16'h0008, 1'b1);
      wr(CODE_WINDOW, 16'h0001, 1'b0);
      rd(11'h078, 16'h0000);
      acc(1'b1, 1'b0, CODE_WINDOW, 16'h0007, 1'b0, 16'h0000);
      acc(1'b0, 1'b1, 11'h0FB, 16'h0000, 1'b1, 16'h0000);
      acc(1'b0, 1'b1, 11'h100, 16'h0000, 1'b1, 16'h0000);
      acc(1'b0, 1'b0, CODE_LAST + 11'h1, 16'h0000, 1'b1, 16'h0000);
      acc(1'b1, 1'b0, CODE_WINDOW, 16'h0000, 1'b0, 16'h0000);
      $display("window done");
      acc(1'b1, 1'b0, CODE_MODULE_EN, 16'h0001, 1'b0, 16'h0000);
      check(16'(module_comm_en), 16'h0000);
      check(16'(ready_out), 16'h0001);
      module_fitted = 1'b1;
      repeat (2) @(negedge mclk);
      check(16'(module_comm_en), 16'h0001);
      acc(1'b1, 1'b0, CODE_MODULE_EN, 16'h0002, 1'b1, 16'h0000);
      wr(CODE_RATE, 16'h0002, 1'b0);
      factory_default_load = 1'b1;
      @(negedge mclk);
      factory_default_load = 1'b0;
      acc(1'b0, 1'b0, CODE_MODULE_EN, 16'h0000, 1'b0, 16'h0001);
      rd(CODE_STATION, 16'h0001);
      check(16'(link_rate), 16'h0000);
      $display("module done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
